/* shared/oag_pkg.sv */
// operand address generator package: modes, data types, request/answer carriers
// assumes a 32-bit general register file of sixteen registers, r15 is the pc
`default_nettype none
package oag_pkg;
  localparam logic [3:0] OAG_PC_IDX = 4'hF;
  localparam logic [31:0] OAG_LONG_STEP = 32'h0000_0004;
  localparam int OAG_LIT_W = 6;

  typedef enum logic [3:0] {
    OAG_M_LITERAL = 4'h0,
    OAG_M_AUTODEC = 4'h7,
    OAG_M_AUTOINC = 4'h8,
    OAG_M_AUTOINC_DEF = 4'h9,
    OAG_M_DISP = 4'hA,
    OAG_M_DISP_DEF = 4'hB,
    OAG_M_BRANCH = 4'hC
  } oag_mode_t;

  typedef enum logic [2:0] {
    OAG_T_BYTE = 3'h0,
    OAG_T_WORD = 3'h1,
    OAG_T_LONG = 3'h2,
    OAG_T_FFLT = 3'h3,
    OAG_T_QUAD = 3'h4,
    OAG_T_DGFLT = 3'h5,
    OAG_T_OCTA = 3'h6,
    OAG_T_HFLT = 3'h7
  } oag_dtype_t;

  // displacement width selector: byte, word, longword
  typedef enum logic [1:0] {
    OAG_D_BYTE = 2'h0,
    OAG_D_WORD = 2'h1,
    OAG_D_LONG = 2'h2
  } oag_dsize_t;

  typedef struct packed {
    oag_mode_t mode;
    oag_dtype_t dtype;
    logic [3:0] reg_idx;
    oag_dsize_t dsize;
    logic [31:0] disp;
    logic indexed;
    logic [3:0] index_idx;
    logic [5:0] literal;
  } oag_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic is_literal;
    logic is_immediate;
    logic [31:0] literal_val;
    logic wb_en;
    logic [3:0] wb_idx;
    logic [31:0] wb_val;
  } oag_rsp_t;

  typedef enum logic [2:0] {
    OAG_S_IDLE = 3'h0,
    OAG_S_CALC = 3'h1,
    OAG_S_FETCH = 3'h2,
    OAG_S_INDEX = 3'h3,
    OAG_S_DONE = 3'h4
  } oag_state_t;
endpackage
`default_nettype wire

/* src/oag_size.sv */
// operand size and scaling: maps data type to its byte count
// assumes types encoded as in the package
`default_nettype none
module oag_size
  import oag_pkg::*;
(
  input wire oag_dtype_t dtype,
  input wire logic [31:0] index_val,
  output logic [31:0] step,
  output logic [31:0] scaled
);
  // byte count of one element
  always_comb begin
    case (dtype)
      OAG_T_BYTE: step = 32'h0000_0001;
      OAG_T_WORD: step = 32'h0000_0002;
      OAG_T_LONG, OAG_T_FFLT: step = 32'h0000_0004;
      OAG_T_QUAD, OAG_T_DGFLT: step = 32'h0000_0008;
      default: step = 32'h0000_0010;
    endcase
  end

  // scale by shift, sizes are powers of two
  always_comb begin
    case (dtype)
      OAG_T_BYTE: scaled = index_val;
      OAG_T_WORD: scaled = {index_val[30:0], 1'b0};
      OAG_T_LONG, OAG_T_FFLT: scaled = {index_val[29:0], 2'b00};
      OAG_T_QUAD, OAG_T_DGFLT: scaled = {index_val[28:0], 3'b000};
      default: scaled = {index_val[27:0], 4'h0};
    endcase
  end
endmodule
`default_nettype wire

/* src/oag_sext.sv */
// displacement sign extension to a full longword
// assumes displacement bits sit in the low end of disp
`default_nettype none
module oag_sext
  import oag_pkg::*;
(
  input wire oag_dsize_t dsize,
  input wire logic [31:0] disp,
  output logic [31:0] ext
);
  // widen by replicating the sign bit of the chosen width
  always_comb begin
    case (dsize)
      OAG_D_BYTE: ext = {{24{disp[7]}}, disp[7:0]};
      OAG_D_WORD: ext = {{16{disp[15]}}, disp[15:0]};
      default: ext = disp;
    endcase
  end
endmodule
`default_nettype wire

/* src/oag_top.sv */
// operand address generator: effective address and register update per specifier
// assumes two register file read ports (base and index), a longword read port and a decoder handshake
// Summary of operation
// (RQ1) autodecrement: reduce register by size first, then use it as address
// (RQ2) step is 1,2,4,8,16 bytes by operand data type
// (RQ3) autoincrement: use register as address, then add operand size
// (RQ4) autoincrement deferred: fetch longword at register, add 4 to register
// (RQ5) pc with autoincrement deferred is absolute, address from instruction stream
// (RQ6) branch: sign-extend byte/word displacement, add to updated pc
// (RQ7) displacement: sign-extend to 32 bits, add to register, address direct
// (RQ8) displacement deferred: register plus displacement, fetch longword as address
// (RQ9) indexed: index register scaled by operand size, added to base address
// (RQ10) indexed base may be autodec, autoinc, autoinc deferred, disp, disp deferred
// (RQ11) pc with plain autoincrement gives an immediate from instruction stream
// (RQ12) literal: six-bit constant from the specifier, no memory access
`default_nettype none
module oag_top
  import oag_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire oag_req_t req,
  output logic [3:0] rf_raddr,
  input wire logic [31:0] rf_rdata,
  output logic [3:0] rf_iaddr,
  input wire logic [31:0] rf_idata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic rsp_valid,
  output oag_rsp_t rsp,
  output logic bad_index
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  oag_state_t state_q, state_d;
  oag_req_t req_q;
  oag_rsp_t rsp_q;
  logic [31:0] base_q;
  logic [31:0] step, scaled, ext;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  oag_size u_size (
    .dtype(req_q.dtype),
    .index_val(rf_idata),
    .step(step),
    .scaled(scaled)
  );

  oag_sext u_sext (
    .dsize(req_q.dsize),
    .disp(req_q.disp),
    .ext(ext)
  );

  // ------------------------------------------------------------
  // decode of the latched specifier
  // ------------------------------------------------------------
  wire is_pc = (req_q.reg_idx == OAG_PC_IDX);
  wire m_lit = (req_q.mode == OAG_M_LITERAL);
  wire m_adec = (req_q.mode == OAG_M_AUTODEC);
  wire m_inc = (req_q.mode == OAG_M_AUTOINC);
  wire m_incd = (req_q.mode == OAG_M_AUTOINC_DEF);
  wire m_disp = (req_q.mode == OAG_M_DISP);
  wire m_dispd = (req_q.mode == OAG_M_DISP_DEF);
  wire m_br = (req_q.mode == OAG_M_BRANCH);
  // base forms that may sit under an index; literal, branch and immediate
  // have no address of their own to index from
  wire base_ok = m_adec | m_inc | m_incd | m_disp | m_dispd; // [RQ10]
  // pc forms take data from the stream; absolute gets its address in disp, immediate answers with the pc
  wire absolute = m_incd & is_pc; // [RQ5]
  wire immediate = m_inc & is_pc; // [RQ11]
  // only these two forms go out to memory for a pointer longword
  wire deferred = (m_incd & ~is_pc) | m_dispd; // [RQ4] [RQ8]
  // size step comes from the data type, so one adder serves every type
  wire [31:0] down_val = rf_rdata - step; // [RQ1] [RQ2]
  wire [31:0] inc_val = rf_rdata + step; // [RQ3] [RQ2]
  wire [31:0] disp_sum = rf_rdata + ext; // [RQ7] [RQ8]
  // branch displacement is byte or word only; the pc on rf_rdata is
  // already past it, so no correction is added here
  wire [31:0] br_sum = rf_rdata + ext; // [RQ6]

  // direct address for the non-deferred modes; for the deferred ones this
  // is the pointer location that goes out on mem_addr
  wire [31:0] calc_addr =
    m_adec ? down_val : // [RQ1]
    absolute ? req_q.disp : // [RQ5]
    m_br ? br_sum : // [RQ6]
    (m_disp | m_dispd) ? disp_sum : // [RQ7] [RQ8]
    rf_rdata; // [RQ3] [RQ4]

  // register write-back per mode; the pc autoincrement forms never write back since the
  // decoder owns the stream pointer
  wire wb_en_c = (m_adec | (m_inc & ~is_pc) | (m_incd & ~is_pc));
  wire [31:0] wb_val_c =
    m_adec ? down_val :
    m_incd ? rf_rdata + OAG_LONG_STEP : // [RQ4]
    inc_val; // [RQ3]

  // handshake outputs straight from state; one specifier at a time, so
  // ready only returns once the answer strobe has gone
  assign req_ready = (state_q == OAG_S_IDLE);
  assign rf_raddr = req_q.reg_idx;
  assign rf_iaddr = req_q.index_idx;
  assign rsp_valid = (state_q == OAG_S_DONE);
  assign rsp = rsp_q;

  // ------------------------------------------------------------
  // sequence: calc, optional fetch, optional index
  // ------------------------------------------------------------
  // next state; a fetch waits on mem_ack with no limit, so the memory
  // side must always answer a read
  always_comb begin
    state_d = state_q;
    case (state_q)
      OAG_S_IDLE: begin
        if (req_valid) begin
          state_d = OAG_S_CALC;
        end
      end
      OAG_S_CALC: begin
        if (deferred) begin
          state_d = OAG_S_FETCH;
        end else if (req_q.indexed & base_ok & ~immediate) begin
          state_d = OAG_S_INDEX;
        end else begin
          state_d = OAG_S_DONE;
        end
      end
      OAG_S_FETCH: begin
        if (mem_ack) begin
          state_d = req_q.indexed ? OAG_S_INDEX : OAG_S_DONE;
        end
      end
      OAG_S_INDEX: state_d = OAG_S_DONE;
      OAG_S_DONE: state_d = OAG_S_IDLE;
      default: state_d = OAG_S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= OAG_S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_q <= '0;
    end else if (req_valid && req_ready) begin
      req_q <= req;
    end
  end

  // memory read for deferred forms; address held until acknowledge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
    end else if (state_q == OAG_S_CALC && deferred) begin
      mem_req <= 1'b1;
      mem_addr <= calc_addr; // [RQ4] [RQ8]
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // bad index: index given on a base that cannot carry one
  // level stays until the next specifier is worked, so it may be read late
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bad_index <= 1'b0;
    end else if (state_q == OAG_S_CALC) begin
      bad_index <= req_q.indexed & (~base_ok | immediate);
    end
  end

  // answer assembly
  // rsp stays put after the strobe so a slow decoder can still take it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_q <= '0;
      base_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        OAG_S_CALC: begin
          rsp_q.addr <= calc_addr;
          base_q <= calc_addr;
          rsp_q.is_literal <= m_lit; // [RQ12]
          rsp_q.literal_val <= {26'h0, req_q.literal}; // [RQ12]
          rsp_q.is_immediate <= immediate; // [RQ11]
          rsp_q.wb_en <= wb_en_c;
          rsp_q.wb_idx <= req_q.reg_idx;
          rsp_q.wb_val <= wb_val_c;
        end
        OAG_S_FETCH: begin
          if (mem_ack) begin
            rsp_q.addr <= mem_rdata; // [RQ4] [RQ8]
            base_q <= mem_rdata;
          end
        end
        OAG_S_INDEX: begin
          rsp_q.addr <= base_q + scaled; // [RQ9]
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  autodec_addr_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ1]
    (state_q == OAG_S_CALC && m_adec && !req_q.indexed)
      |=> (rsp_valid && rsp.addr == $past(rf_rdata) - $past(step)))
    else $error("autodecrement address wrong");
  step_size_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
    (req_q.dtype == OAG_T_WORD) |-> step == 32'h0000_0002)
    else $error("word step not two");
  autoinc_post_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ3]
    (state_q == OAG_S_CALC && m_inc && !is_pc)
      |=> (rsp.addr == $past(rf_rdata) && rsp.wb_val == $past(rf_rdata) + $past(step)))
    else $error("autoincrement update wrong");
  incdef_four_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
    (state_q == OAG_S_CALC && m_incd && !is_pc)
      |=> (mem_req && rsp.wb_val == $past(rf_rdata) + 32'h0000_0004))
    else $error("deferred increment not four");
  absolute_addr_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
    (state_q == OAG_S_CALC && absolute && !req_q.indexed)
      |=> (rsp_valid && !rsp.wb_en && rsp.addr == $past(req_q.disp)))
    else $error("absolute address wrong");
  branch_tgt_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ6]
    (state_q == OAG_S_CALC && m_br)
      |=> rsp.addr == $past(rf_rdata) + $past(ext))
    else $error("branch target wrong");
  disp_sext_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ7]
    (req_q.dsize == OAG_D_BYTE) |-> ext[31:8] == {24{req_q.disp[7]}})
    else $error("byte displacement not extended");
  dispdef_fetch_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
    (state_q == OAG_S_FETCH && mem_ack && !req_q.indexed)
      |=> (rsp_valid && rsp.addr == $past(mem_rdata)))
    else $error("deferred address not fetched");
  index_scale_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ9]
    (state_q == OAG_S_INDEX) |=> rsp.addr == $past(base_q) + $past(scaled))
    else $error("indexed address wrong");
  index_base_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
    (state_q == OAG_S_CALC && req_q.indexed && m_disp) |=> state_q == OAG_S_INDEX)
    else $error("indexed base refused");
  immediate_flag_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ11]
    (state_q == OAG_S_CALC && immediate) |=> (rsp.is_immediate && !rsp.wb_en))
    else $error("immediate not flagged");
  literal_value_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ12]
    (state_q == OAG_S_CALC && m_lit)
      |=> (!mem_req && rsp.is_literal && rsp.literal_val[5:0] == $past(req_q.literal)))
    else $error("literal wrong");

  // ------------------------------------------------------------
  // read port and answer checks
  // ------------------------------------------------------------
  // write-back of autodecrement carries the reduced value, indexed or not
  autodec_wb_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ1]
    (state_q == OAG_S_CALC && m_adec)
      |=> (rsp.wb_en && rsp.wb_val == $past(rf_rdata) - $past(step)))
    else $error("autodecrement write-back wrong");
  // pointer fetch goes to the register itself, not to a stepped value
  incdef_addr_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
    (state_q == OAG_S_CALC && m_incd && !is_pc)
      |=> (mem_addr == $past(rf_rdata)))
    else $error("deferred pointer address wrong");
  // plain displacement without index answers at once and never touches memory
  disp_direct_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ7]
    (state_q == OAG_S_CALC && m_disp && !req_q.indexed)
      |=> (rsp_valid && !mem_req && !rsp.wb_en && rsp.addr == $past(rf_rdata) + $past(ext)))
    else $error("displacement address wrong");
  // pointer location is register plus extended displacement
  dispdef_addr_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
    (state_q == OAG_S_CALC && m_dispd)
      |=> (mem_req && mem_addr == $past(rf_rdata) + $past(ext)))
    else $error("deferred displacement address wrong");
  // a slow memory must see a steady request until it answers
  read_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
    (mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr)))
    else $error("read request dropped early");
  // index under a literal has no base address and is flagged
  index_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
    (state_q == OAG_S_CALC && m_lit && req_q.indexed) |=> (bad_index && rsp_valid))
    else $error("index on literal not flagged");
  // immediate answers with the pc value and no read of its own
  immediate_addr_a: assert property (@(posedge clk) disable iff (!rstn) // [RQ11]
    (state_q == OAG_S_CALC && immediate) |=> (!mem_req && rsp.addr == $past(rf_rdata)))
    else $error("immediate address wrong");
endmodule
`default_nettype wire

/* sim/oag_far_model.sv */
// far side model: combinational register file and a longword read port
// assumes the design holds mem_req high until it samples mem_ack
`default_nettype none
module oag_far_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [3:0] rf_raddr,
  output logic [31:0] rf_rdata,
  input wire logic [3:0] rf_iaddr,
  output logic [31:0] rf_idata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;
  // ----------------------------------------
  // register contents are a pure function of the index
  // ----------------------------------------
  assign rf_rdata = 32'h0000_1000 + {20'h0, rf_raddr, 8'h00};
  assign rf_idata = 32'h0000_0001 + {28'h0, rf_iaddr};
  // ----------------------------------------
  // read answer after 0 or 5 waits
  // ----------------------------------------
  // data churns outside the ack cycle so a late sample is caught
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      cnt_q <= 3'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt_q == (slow ? 3'h5 : 3'h0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= ~mem_addr;
      cnt_q <= 3'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= mem_rdata + 32'h1357_9BDF;
      cnt_q <= (mem_req && !mem_ack) ? cnt_q + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

/* sim/oag_top_bench.sv */
// operand address generator bench: table of specifiers, then hand cases
// assumes the far model gives registers and longword reads
`default_nettype none
module oag_top_bench
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    oag_mode_t m; oag_dtype_t t; logic [3:0] r; oag_dsize_t s; logic [31:0] d;
    logic [4:0] x; logic w;
  } oagb_row_t;
  logic clk, rstn, req_valid, req_ready, mem_req, mem_ack, rsp_valid, bad_index, slow, seen;
  logic [3:0] rf_raddr, rf_iaddr;
  logic [31:0] rf_rdata, rf_idata, mem_addr, mem_rdata;
  logic [63:0] ab;
  oag_req_t req, q;
  oag_rsp_t rsp;
  int fails = 0, n_compared = 0, cyc = 0;
  oagb_row_t rows [20] = '{
    '{OAG_M_AUTODEC, OAG_T_BYTE, 4'h2, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTODEC, OAG_T_WORD, 4'h3, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTOINC, OAG_T_LONG, 4'h4, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTOINC, OAG_T_FFLT, 4'h5, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTOINC, OAG_T_QUAD, 4'h6, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTODEC, OAG_T_DGFLT, 4'h7, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTOINC, OAG_T_OCTA, 4'h8, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTODEC, OAG_T_HFLT, 4'h9, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_AUTOINC_DEF, OAG_T_WORD, 4'hA, OAG_D_BYTE, 32'h0, 5'h00, 1'b1},
    '{OAG_M_DISP, OAG_T_LONG, 4'h1, OAG_D_BYTE, 32'h80, 5'h00, 1'b0},
    '{OAG_M_DISP, OAG_T_LONG, 4'h2, OAG_D_WORD, 32'hFFFE, 5'h00, 1'b0},
    '{OAG_M_DISP, OAG_T_LONG, 4'h3, OAG_D_LONG, 32'hFFFF_FF10, 5'h00, 1'b0},
    '{OAG_M_DISP_DEF, OAG_T_BYTE, 4'h4, OAG_D_BYTE, 32'h17F, 5'h00, 1'b0},
    '{OAG_M_BRANCH, OAG_T_BYTE, 4'hF, OAG_D_BYTE, 32'hF0, 5'h00, 1'b0},
    '{OAG_M_BRANCH, OAG_T_WORD, 4'hF, OAG_D_WORD, 32'h9234, 5'h00, 1'b0},
    '{OAG_M_AUTODEC, OAG_T_LONG, 4'h2, OAG_D_BYTE, 32'h0, 5'h13, 1'b1},
    '{OAG_M_AUTOINC, OAG_T_WORD, 4'h3, OAG_D_BYTE, 32'h0, 5'h15, 1'b1},
    '{OAG_M_AUTOINC_DEF, OAG_T_QUAD, 4'h4, OAG_D_BYTE, 32'h0, 5'h16, 1'b1},
    '{OAG_M_DISP, OAG_T_OCTA, 4'h5, OAG_D_WORD, 32'h8000, 5'h17, 1'b0},
    '{OAG_M_DISP_DEF, OAG_T_BYTE, 4'h6, OAG_D_BYTE, 32'hFF, 5'h18, 1'b0}};
  oag_top u_oag_top (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_iaddr(rf_iaddr),
    .rf_idata(rf_idata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rsp_valid(rsp_valid), .rsp(rsp), .bad_index(bad_index));
  oag_far_model u_oag_far_model (.clk(clk), .rstn(rstn), .slow(slow), .rf_raddr(rf_raddr),
    .rf_rdata(rf_rdata), .rf_iaddr(rf_iaddr), .rf_idata(rf_idata), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ----------------------------------------
  // reference arithmetic, same register contents as the far model
  // ----------------------------------------
  function automatic logic [31:0] step(oag_dtype_t t);
    case (t)
      OAG_T_BYTE: return 32'h1;
      OAG_T_WORD: return 32'h2;
      OAG_T_LONG, OAG_T_FFLT: return 32'h4;
      OAG_T_QUAD, OAG_T_DGFLT: return 32'h8;
      default: return 32'h10;
    endcase
  endfunction
  function automatic logic [31:0] sx(oag_dsize_t s, logic [31:0] d);
    if (s == OAG_D_BYTE) return {{24{d[7]}}, d[7:0]};
    if (s == OAG_D_WORD) return {{16{d[15]}}, d[15:0]};
    return d;
  endfunction
  // returns address in the upper half, write-back value in the lower
  function automatic logic [63:0] ref_of(oagb_row_t w);
    logic [31:0] rv, a, b;
    rv = 32'h1000 + {20'h0, w.r, 8'h00};
    b = rv + step(w.t);
    case (w.m)
      OAG_M_AUTODEC: begin a = rv - step(w.t); b = a; end
      OAG_M_AUTOINC: a = rv;
      OAG_M_AUTOINC_DEF: begin a = ~rv; b = rv + 32'h4; end
      OAG_M_DISP_DEF: a = ~(rv + sx(w.s, w.d));
      default: a = rv + sx(w.s, w.d);
    endcase
    if (w.x[4]) a = a + (32'h1 + {28'h0, w.x[3:0]}) * step(w.t);
    return {a, b};
  endfunction
  task automatic check(string name, logic [31:0] seen_v, logic [31:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask
  // one transfer: offer, release after the taking edge, wait for the answer
  task automatic run(oag_req_t r);
    bit got;
    got = 0;
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    seen = 0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge clk);
      if (mem_req === 1'b1) seen = 1;
      if (rsp_valid === 1'b1) got = 1;
    end
    check("rsp_valid", {31'h0, got}, 32'h1);
  endtask
  function automatic oag_req_t mk(oagb_row_t w);
    return '{w.m, w.t, w.r, w.s, w.d, w.x[4], w.x[3:0], 6'h00};
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // hang guard, runs are far shorter than this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    rstn = 0;
    req_valid = 0;
    req = '0;
    slow = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check("idle ready", {31'h0, req_ready}, 32'h1);
    check("idle mem_req", {31'h0, mem_req}, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      ab = ref_of(rows[i]);
      run(mk(rows[i]));
      check("addr", rsp.addr, ab[63:32]);
      check("wb_en", {31'h0, rsp.wb_en}, {31'h0, rows[i].w});
      if (rows[i].w) check("wb_val", rsp.wb_val, ab[31:0]);
      if (rows[i].w) check("wb_idx", {28'h0, rsp.wb_idx}, {28'h0, rows[i].r});
      check("bad_index", {31'h0, bad_index}, 32'h0);
    end
    $display("test table done");
    slow <= 1'b1;
    ab = ref_of(rows[19]);
    run(mk(rows[19]));
    check("slow addr", rsp.addr, ab[63:32]);
    slow <= 1'b0;
    $display("test slow memory done");
    q = mk(rows[2]);
    q.reg_idx = 4'hF;
    q.disp = 32'hCAFE_0001;
    run(q);
    check("immediate", {31'h0, rsp.is_immediate}, 32'h1);
    check("imm wb", {31'h0, rsp.wb_en}, 32'h0);
    check("imm mem", {31'h0, seen}, 32'h0);
    q.mode = OAG_M_AUTOINC_DEF;
    run(q);
    check("absolute", rsp.addr, 32'hCAFE_0001);
    check("abs mem", {31'h0, seen}, 32'h0);
    check("abs wb", {31'h0, rsp.wb_en}, 32'h0);
    $display("test pc modes done");
    q = '0;
    q.mode = OAG_M_LITERAL;
    q.literal = 6'h2A;
    run(q);
    check("is_literal", {31'h0, rsp.is_literal}, 32'h1);
    check("literal_val", rsp.literal_val, 32'h2A);
    check("lit mem", {31'h0, seen}, 32'h0);
    q.indexed = 1'b1;
    run(q);
    check("bad_index", {31'h0, bad_index}, 32'h1);
    $display("test literal done");
    // reset in the middle of a slow pointer fetch must drop the read
    slow <= 1'b1;
    @(posedge clk);
    req <= mk(rows[12]);
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rst ready", {31'h0, req_ready}, 32'h1);
    check("rst mem_req", {31'h0, mem_req}, 32'h0);
    check("rst rsp_valid", {31'h0, rsp_valid}, 32'h0);
    check("rst bad_index", {31'h0, bad_index}, 32'h0);
    check("rst addr", rsp.addr, 32'h0);
    @(posedge clk);
    rstn <= 1'b1;
    slow <= 1'b0;
    ab = ref_of(rows[15]);
    run(mk(rows[15]));
    check("rerun addr", rsp.addr, ab[63:32]);
    check("rerun wb_val", rsp.wb_val, ab[31:0]);
    $display("test mid reset done");
    end_sim();
  end
endmodule
`default_nettype wire
